// ==== src/isrc_receiver.sv ====
// isochronous stream receiver: filter, source packet rebuild, av delivery, registers
`timescale 1ns/100ps
`default_nettype none
module isrc_receiver (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   input wire isrc_pkg::isrc_link_s linkIn,
   input wire logic [15:0] cycleTime,
   output isrc_pkg::isrc_av_s avOut,
   output logic linkBusy,
   output logic avBusy,
   output logic irq
);
   import isrc_pkg::*;

   typedef enum {L_IDLE, L_CIP0, L_CIP1, L_DATA, L_SKIP} isrc_lst_e;
   typedef enum {A_IDLE, A_WAIT, A_DATA} isrc_ast_e;

   // source packet size in quadlets; a block size of zero means 256
   function automatic logic [11:0] spQuads(input logic [7:0] dbs, input logic [1:0] fn);
      logic [11:0] n;
      n = {3'h0, (dbs == 8'h00), dbs};
      spQuads = n << fn;
   endfunction : spQuads

   // ------------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------------
   logic rxReset_r, rxEnable_r, stampEn_r, rmvUnrel_r;
   logic [1:0] bytePad_r, tag_r;
   logic [5:0] chan_r;
   logic [NUM_EV-1:0] ev_r, evEn_r, evSet, evAck;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxReset_r <= RX_RESET_INIT;
         rxEnable_r <= 1'b0;
         stampEn_r <= 1'b0;
         rmvUnrel_r <= 1'b0;
         bytePad_r <= 2'h0;
         tag_r <= 2'h0;
         chan_r <= 6'h00;
         evEn_r <= '0;
      end else if (regWr) begin
         if (regAddr == REG_CTRL) begin
            rxReset_r <= regWrData[CTRL_RX_RESET];
            rxEnable_r <= regWrData[CTRL_RX_ENABLE];
            stampEn_r <= regWrData[CTRL_STAMP_EN];
            bytePad_r <= regWrData[CTRL_BPAD_LSB +: 2];
            rmvUnrel_r <= regWrData[CTRL_RMV_UNREL];
         end else if (regAddr == REG_FILTER) begin
            chan_r <= regWrData[FILT_CHAN_LSB +: 6];
            tag_r <= regWrData[FILT_TAG_LSB +: 2];
         end else if (regAddr == REG_EVENT_EN) begin
            evEn_r <= regWrData[NUM_EV-1:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // buffer state shared by both sides
   // ------------------------------------------------------------------
   logic [31:0] mem [0:(1 << MEM_AW)-1];
   logic [10:0] wrPtr, rdPtr, memCnt, memFree;
   logic [5:0] spWr, spRd, spPend, spCnt;
   logic unrelQ [0:31];
   logic memFull, memOneFree, memFiveFree, memEmpty, memFullD_r, memEmptyD_r;

   assign memCnt = wrPtr - rdPtr;
   assign memFree = MEM_DEPTH - memCnt;
   assign memFull = (memCnt == MEM_DEPTH);
   assign memOneFree = (memFree == 11'h001);
   assign memFiveFree = (memFree >= MEM_FIVE_FREE);
   assign memEmpty = (memCnt == 11'h000);
   assign spCnt = spWr - spRd;

   // ------------------------------------------------------------------
   // link side
   // ------------------------------------------------------------------
   isrc_lst_e lSt;
   logic [31:0] cip0_r, cip1_r;
   logic [11:0] quadInSp, spQ;
   logic [8:0] blkQuad;
   logic [7:0] blkCnt, expDbc_r;
   logic [10:0] spBase;
   logic havePrev_r, carryUnrel_r, spDrop_r, pktUnrel;
   logic [1:0] spd_r;
   logic [3:0] err_r, sync_r;
   logic dataWr, spDone, spKeep, sqovHit, lastP, seqP, cipP, memWe;
   logic [5:0] pendNow;

   assign spQ = spQuads(cip0_r[23:16], cip0_r[15:14]);
   assign dataWr = (lSt == L_DATA) && linkIn.valid;
   assign memWe = dataWr && !memFull;
   assign spDone = dataWr && (quadInSp == spQ - 12'h001);
   assign sqovHit = (spCnt + spPend) >= SPQ_DEPTH;
   assign spKeep = spDone && !spDrop_r && !memFull && !sqovHit;
   assign pendNow = spPend + {5'h00, spKeep};
   assign lastP = dataWr && linkIn.last;
   assign seqP = (lSt == L_CIP0) && linkIn.valid && havePrev_r && (linkIn.data[7:0] != expDbc_r);
   assign cipP = (lSt == L_CIP1) && linkIn.valid &&
      ((cip0_r[31:30] != CIP_EF0_OK) || (linkIn.data[31:30] != CIP_EF1_OK));
   assign pktUnrel = linkIn.crcErr || carryUnrel_r;
   assign linkBusy = (lSt != L_IDLE);

   always_ff @(posedge ref_clk) begin
      if (memWe) begin
         mem[wrPtr[MEM_AW-1:0]] <= linkIn.data;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lSt <= L_IDLE;
         cip0_r <= '0;
         cip1_r <= '0;
         quadInSp <= '0;
         blkQuad <= '0;
         blkCnt <= '0;
         expDbc_r <= '0;
         havePrev_r <= 1'b0;
         carryUnrel_r <= 1'b0;
         spDrop_r <= 1'b0;
         wrPtr <= '0;
         spBase <= '0;
         spPend <= '0;
         spWr <= '0;
         spd_r <= '0;
         err_r <= '0;
         sync_r <= '0;
      end else if (rxReset_r) begin
         lSt <= L_IDLE;
         quadInSp <= '0;
         blkQuad <= '0;
         blkCnt <= '0;
         havePrev_r <= 1'b0;
         carryUnrel_r <= 1'b0;
         spDrop_r <= 1'b0;
         wrPtr <= '0;
         spBase <= '0;
         spPend <= '0;
         spWr <= '0;
      end else if (linkIn.valid) begin
         case (lSt)
            L_IDLE: begin
               // enable only sampled at packet start, so a running packet completes
               if (linkIn.first && !linkIn.last) begin
                  if (rxEnable_r && linkIn.data[13:8] == chan_r && linkIn.data[15:14] == tag_r) begin
                     lSt <= L_CIP0;
                     sync_r <= linkIn.data[3:0];
                  end else begin
                     lSt <= L_SKIP;
                  end
               end
            end
            L_CIP0: begin
               cip0_r <= linkIn.data;
               blkCnt <= '0;
               lSt <= linkIn.last ? L_IDLE : L_CIP1;
            end
            L_CIP1: begin
               if (cipP || linkIn.last) begin
                  lSt <= linkIn.last ? L_IDLE : L_SKIP;
               end else begin
                  cip1_r <= linkIn.data;
                  lSt <= L_DATA;
               end
            end
            L_DATA: begin
               if (memWe) begin
                  wrPtr <= wrPtr + 11'h001;
               end else begin
                  spDrop_r <= 1'b1;
               end
               if (blkQuad == {(cip0_r[23:16] == 8'h00), cip0_r[23:16]} - 9'h001) begin
                  blkQuad <= '0;
                  blkCnt <= blkCnt + 8'h01;
               end else begin
                  blkQuad <= blkQuad + 9'h001;
               end
               if (spDone) begin
                  quadInSp <= '0;
                  spDrop_r <= 1'b0;
                  if (spKeep) begin
                     spBase <= wrPtr + 11'h001;
                  end else begin
                     wrPtr <= spBase;
                  end
               end else begin
                  quadInSp <= quadInSp + 12'h001;
               end
               spPend <= pendNow;
               if (linkIn.last) begin
                  // source packets become visible only once the bus packet crc is known
                  spWr <= spWr + pendNow;
                  spPend <= '0;
                  carryUnrel_r <= pktUnrel && !spDone;
                  expDbc_r <= cip0_r[7:0] + blkCnt + {7'h00, blkQuad == {(cip0_r[23:16] == 8'h00),
                     cip0_r[23:16]} - 9'h001};
                  havePrev_r <= 1'b1;
                  spd_r <= linkIn.spd;
                  err_r <= linkIn.err;
                  lSt <= L_IDLE;
               end
            end
            default: begin
               if (linkIn.last) begin
                  lSt <= L_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (lastP) begin
         for (int i = 0; i < 32; i++) begin
            if (5'(i - int'(spWr[4:0])) < pendNow[4:0] || pendNow == SPQ_DEPTH) begin
               unrelQ[i] <= pktUnrel;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // frame sync from the syt stamp
   // ------------------------------------------------------------------
   logic [15:0] syt_r;
   logic sytPend_r, fsyncP;

   assign fsyncP = stampEn_r && sytPend_r && (cycleTime == syt_r);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         syt_r <= SYT_NONE;
         sytPend_r <= 1'b0;
      end else if (rxReset_r || !stampEn_r) begin
         sytPend_r <= 1'b0;
      end else if (lSt == L_CIP1 && linkIn.valid && !cipP && linkIn.data[15:0] != SYT_NONE) begin
         syt_r <= linkIn.data[15:0];
         sytPend_r <= 1'b1;
      end else if (fsyncP) begin
         sytPend_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // application side
   // ------------------------------------------------------------------
   isrc_ast_e aSt;
   logic [1:0] avDiv;
   logic avTick, avUnrel_r, hasStamp, stampReached, avShow;
   logic [13:0] byteCnt, totBytes;
   logic [11:0] payQuads;
   logic [10:0] rdAddr;
   logic [31:0] rdWord;
   logic [15:0] stampDiff;

   assign avTick = (avDiv == AV_DIV);
   assign hasStamp = cip0_r[10];
   assign payQuads = spQ - {11'h000, hasStamp} - {9'h000, cip0_r[13:11]};
   assign totBytes = {payQuads, 2'h0} - {12'h000, bytePad_r};
   assign rdAddr = rdPtr + {10'h000, hasStamp} + byteCnt[12:2];
   assign rdWord = mem[rdAddr[MEM_AW-1:0]];
   assign stampDiff = cycleTime - mem[rdPtr[MEM_AW-1:0]][15:0];
   assign stampReached = !stampDiff[15];
   assign avShow = !(rmvUnrel_r && avUnrel_r);
   assign avBusy = (aSt != A_IDLE);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         avDiv <= '0;
      end else begin
         avDiv <= avTick ? 2'h0 : avDiv + 2'h1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         aSt <= A_IDLE;
         rdPtr <= '0;
         spRd <= '0;
         byteCnt <= '0;
         avUnrel_r <= 1'b0;
         avOut <= '0;
      end else if (rxReset_r) begin
         aSt <= A_IDLE;
         rdPtr <= '0;
         spRd <= '0;
         byteCnt <= '0;
         avOut <= '0;
      end else begin
         avOut.valid <= 1'b0;
         avOut.sync <= 1'b0;
         avOut.fsync <= fsyncP;
         case (aSt)
            A_IDLE: begin
               if (rxEnable_r && spCnt != 6'h00) begin
                  aSt <= A_WAIT;
                  avUnrel_r <= unrelQ[spRd[4:0]];
                  byteCnt <= '0;
               end
            end
            A_WAIT: begin
               if (!(stampEn_r && hasStamp) || stampReached) begin
                  aSt <= A_DATA;
               end
            end
            default: begin
               if (avTick) begin
                  avOut.data <= rdWord[(5'd24 - {byteCnt[1:0], 3'h0}) +: 8];
                  avOut.valid <= avShow;
                  avOut.sync <= avShow && (byteCnt == 14'h0000);
                  byteCnt <= byteCnt + 14'h0001;
                  if (byteCnt == totBytes - 14'h0001) begin
                     rdPtr <= rdPtr + spQ[10:0];
                     spRd <= spRd + 6'h01;
                     aSt <= A_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // events and interrupt
   // ------------------------------------------------------------------
   always_comb begin
      evSet = '0;
      evSet[EV_FULL] = memFull && !memFullD_r;
      evSet[EV_EMPTY] = memEmpty && !memEmptyD_r;
      evSet[EV_FSYNC] = fsyncP;
      evSet[EV_SEQERR] = seqP;
      evSet[EV_CRCERR] = lastP && linkIn.crcErr;
      evSet[EV_CIPFLT] = cipP;
      evSet[EV_RCVBP] = lastP;
      evSet[EV_SQOV] = spDone && sqovHit;
      evAck = (regWr && regAddr == REG_EVENT) ? regWrData[NUM_EV-1:0] : '0;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ev_r <= '0;
         memFullD_r <= 1'b0;
         memEmptyD_r <= 1'b1;
      end else begin
         ev_r <= (ev_r & ~evAck) | evSet;
         memFullD_r <= memFull;
         memEmptyD_r <= memEmpty;
      end
   end

   assign irq = |(ev_r & evEn_r);

   // ------------------------------------------------------------------
   // register read
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         regRdData <= '0;
      end else if (regRd) begin
         if (regAddr == REG_CTRL) begin
            regRdData <= {26'h0, rmvUnrel_r, bytePad_r, stampEn_r, rxEnable_r, rxReset_r};
         end else if (regAddr == REG_FILTER) begin
            regRdData <= {22'h0, tag_r, 2'h0, chan_r};
         end else if (regAddr == REG_EVENT) begin
            regRdData <= {24'h0, ev_r};
         end else if (regAddr == REG_EVENT_EN) begin
            regRdData <= {24'h0, evEn_r};
         end else if (regAddr == REG_STATUS) begin
            regRdData <= {13'h0, avBusy, linkBusy, spCnt != 6'h00, sync_r, err_r, 2'h0, spd_r,
               memEmpty, memFiveFree, memOneFree, memFull};
         end else if (regAddr == REG_CIP_Q0) begin
            regRdData <= cip0_r;
         end else if (regAddr == REG_CIP_Q1) begin
            regRdData <= cip1_r;
         end else begin
            regRdData <= '0;
         end
      end else begin
         regRdData <= '0;
      end
   end
endmodule : isrc_receiver
`default_nettype wire

// ==== src/isrc_pkg.sv ====
// constants, register map and carrier types of the isochronous stream receiver
`default_nettype none
package isrc_pkg;
   // ------------------------------------------------------------------
   // register map (byte offsets)
   // ------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_FILTER = 8'h04;
   localparam logic [7:0] REG_EVENT = 8'h08;
   localparam logic [7:0] REG_EVENT_EN = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_CIP_Q0 = 8'h14;
   localparam logic [7:0] REG_CIP_Q1 = 8'h18;
   // ------------------------------------------------------------------
   // control fields and reset values
   // ------------------------------------------------------------------
   localparam int CTRL_RX_RESET = 0;
   localparam int CTRL_RX_ENABLE = 1;
   localparam int CTRL_STAMP_EN = 2;
   localparam int CTRL_BPAD_LSB = 3;
   localparam int CTRL_RMV_UNREL = 5;
   localparam int FILT_CHAN_LSB = 0;
   localparam int FILT_TAG_LSB = 8;
   localparam logic RX_RESET_INIT = 1'b1;
   // ------------------------------------------------------------------
   // event bit positions
   // ------------------------------------------------------------------
   localparam int EV_FULL = 0;
   localparam int EV_EMPTY = 1;
   localparam int EV_FSYNC = 2;
   localparam int EV_SEQERR = 3;
   localparam int EV_CRCERR = 4;
   localparam int EV_CIPFLT = 5;
   localparam int EV_RCVBP = 6;
   localparam int EV_SQOV = 7;
   localparam int NUM_EV = 8;
   // ------------------------------------------------------------------
   // buffer sizes and rates
   // ------------------------------------------------------------------
   localparam int MEM_AW = 10;
   localparam logic [10:0] MEM_DEPTH = 11'h400;
   localparam logic [10:0] MEM_FIVE_FREE = 11'h005;
   localparam logic [5:0] SPQ_DEPTH = 6'h20;
   localparam logic [1:0] AV_DIV = 2'h3;
   localparam logic [15:0] SYT_NONE = 16'hffff;
   localparam logic [1:0] CIP_EF0_OK = 2'h0;
   localparam logic [1:0] CIP_EF1_OK = 2'h2;
   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic first;
      logic last;
      logic [31:0] data;
      logic crcErr;
      logic [1:0] spd;
      logic [3:0] err;
   } isrc_link_s;
   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic sync;
      logic fsync;
   } isrc_av_s;
endpackage : isrc_pkg
`default_nettype wire

// ==== verification/isrc_receiver_properties.sv ====
// port checker for the isochronous stream receiver
`timescale 1ns/100ps
`default_nettype none
module isrc_receiver_properties (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdData,
   input wire isrc_pkg::isrc_link_s linkIn,
   input wire logic [15:0] cycleTime,
   input wire isrc_pkg::isrc_av_s avOut,
   input wire logic linkBusy,
   input wire logic avBusy,
   input wire logic irq
);
   import isrc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [5:0] ctrlSh_r;
   // shadow of the control word as software wrote it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrlSh_r <= 6'h01;
      end else if (regWr && regAddr == REG_CTRL) begin
         ctrlSh_r <= regWrData[5:0];
      end
   end
   rd_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0)
      else $error("read data not zero outside a read");
   ctrl_back_a: assert property (regRd && regAddr == REG_CTRL |=> regRdData[5:0] == ctrlSh_r)
      else $error("control readback differs from written value");
   rst_bit_a: assert property (regRd && regAddr == REG_CTRL && ctrlSh_r[0] |=> regRdData[0])
      else $error("receiver reset bit cleared by itself");
   unmapped_a: assert property (regRd && regAddr > REG_CIP_Q1 |=> regRdData == 32'h0)
      else $error("unmapped read not zero");
   stat_busy_a: assert property (regRd && regAddr == REG_STATUS |=>
      regRdData[17] == $past(linkBusy) && regRdData[18] == $past(avBusy))
      else $error("status busy bits differ from ports");
   flags_excl_a: assert property (regRd && regAddr == REG_STATUS |=>
      !(regRdData[0] && (regRdData[2] || regRdData[3])) && !(regRdData[1] && regRdData[2]))
      else $error("buffer level flags contradict");
   rst_hold_a: assert property (ctrlSh_r[0] && $past(ctrlSh_r[0]) |-> !linkBusy && !avBusy)
      else $error("datapath active while receiver reset");
   irq_off_a: assert property (regWr && regAddr == REG_EVENT_EN && regWrData[7:0] == 8'h00 |=> !irq)
      else $error("irq with all events disabled");
   sync_valid_a: assert property (avOut.sync |-> avOut.valid)
      else $error("packet sync without valid");
   byte_gap_a: assert property (avOut.valid |=> !avOut.valid [*3])
      else $error("av bytes closer than four clocks");
   cover property (avOut.sync);
   cover property (irq);
   cover property (linkBusy ##1 !linkBusy);
   cover property (avOut.fsync);
endmodule : isrc_receiver_properties
bind isrc_receiver isrc_receiver_properties chk (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .linkIn(linkIn),
   .cycleTime(cycleTime), .avOut(avOut), .linkBusy(linkBusy), .avBusy(avBusy), .irq(irq));
`default_nettype wire

// ==== verification/isrc_link_model.sv ====
// serial bus link layer model feeding isochronous packets
`timescale 1ns/100ps
`default_nettype none
module isrc_link_model (
   input wire logic ref_clk,
   output isrc_pkg::isrc_link_s linkIn
);
   import isrc_pkg::*;
   initial linkIn = '0;
   // one quadlet, then a gap with the data line toggled
   task automatic put(input logic [31:0] q, input logic fst, input logic lst, input logic crc);
      @(posedge ref_clk);
      linkIn <= '{valid: 1'b1, first: fst, last: lst, data: q, crcErr: crc, spd: 2'h2, err: 4'h1};
      @(posedge ref_clk);
      linkIn <= '{valid: 1'b0, first: 1'b0, last: 1'b0, data: ~q, crcErr: 1'b0, spd: 2'h0, err: 4'h0};
   endtask : put
   task automatic send(input logic [1:0] tag, input logic [5:0] chan, input logic [3:0] sy,
      input logic [31:0] q0, input logic [31:0] q1, input logic [31:0] d, input logic crc);
      put({16'h0, tag, chan, 4'h0, sy}, 1'b1, 1'b0, 1'b0);
      put(q0, 1'b0, 1'b0, 1'b0);
      put(q1, 1'b0, 1'b0, 1'b0);
      put(d, 1'b0, 1'b1, crc);
   endtask : send
endmodule : isrc_link_model
`default_nettype wire

// ==== verification/test_iso_stream_receiver_control.sv ====
// self-checking bench for the isochronous stream receiver
`timescale 1ns/100ps
`default_nettype none
module test_iso_stream_receiver_control;
   import isrc_pkg::*;
   localparam logic [31:0] CIP1 = 32'ha000ffff;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdData;
   logic [15:0] cycleTime = 16'h0;
   isrc_link_s linkIn;
   isrc_av_s avOut;
   logic linkBusy;
   logic avBusy;
   logic irq;
   int mismatches = 0;
   int tests_run = 0;
   int fsyncCnt = 0;
   logic [8:0] avQ[$];
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cycleTime <= cycleTime + 16'h1;
   always @(posedge ref_clk) if (avOut.valid === 1'b1) avQ.push_back({avOut.sync, avOut.data});
   always @(posedge ref_clk) if (avOut.fsync === 1'b1) fsyncCnt++;
   isrc_receiver uut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .linkIn(linkIn), .cycleTime(cycleTime),
      .avOut(avOut), .linkBusy(linkBusy), .avBusy(avBusy), .irq(irq));
   isrc_link_model link (.ref_clk(ref_clk), .linkIn(linkIn));
   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   function automatic logic [31:0] cip0(input logic [1:0] ef, input logic [7:0] dbc);
      return {ef, 6'h03, 8'h01, 2'h0, 3'h0, 1'b0, 2'h0, dbc};
   endfunction : cip0
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
      // let the written value settle before any caller looks at outputs
      #1;
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1;
      chk(regRdData & m, exp);
   endtask : rchk
   task automatic settle;
      int i;
      repeat (6) @(posedge ref_clk);
      for (i = 0; i < 500; i++) begin
         if (linkBusy === 1'b0 && avBusy === 1'b0) break;
         @(posedge ref_clk);
      end
      repeat (6) @(posedge ref_clk);
   endtask : settle
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_regs;
      rchk(REG_CTRL, 32'h1, 32'h3f);
      rchk(8'h40, 32'h0, 32'hffffffff);
      wr(REG_FILTER, 32'h105);
      rchk(REG_FILTER, 32'h105, 32'h33f);
      wr(REG_EVENT_EN, 32'hff);
      rchk(REG_EVENT_EN, 32'hff, 32'hff);
      wr(REG_CTRL, 32'h0a);
      rchk(REG_CTRL, 32'h0a, 32'h3f);
      wr(REG_EVENT, 32'hff);
   endtask : t_regs
   task automatic t_good;
      int i;
      avQ.delete();
      link.send(2'h1, 6'h05, 4'h9, cip0(2'h0, 8'h00), CIP1, 32'ha1b2c3d4, 1'b0);
      settle;
      chk(32'(avQ.size()), 32'h3);
      for (i = 0; i < 3; i++) begin
         chk({23'h0, avQ[i]}, {23'h0, i == 0, 8'(32'ha1b2c3d4 >> (24 - 8 * i))});
      end
      rchk(REG_EVENT, 32'h40, 32'h40);
      rchk(REG_STATUS, 32'h0912c, 32'h7ffff);
      rchk(REG_CIP_Q0, cip0(2'h0, 8'h00), 32'hffffffff);
      chk({31'h0, irq}, 32'h1);
      wr(REG_EVENT_EN, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask : t_good
   task automatic t_filter;
      logic [7:0] fv [2] = '{8'h46, 8'h85};
      int i;
      for (i = 0; i < 2; i++) begin
         wr(REG_EVENT, 32'hff);
         avQ.delete();
         link.send(fv[i][7:6], fv[i][5:0], 4'h0, cip0(2'h0, 8'h01), CIP1, 32'h11223344, 1'b0);
         settle;
         chk(32'(avQ.size()), 32'h0);
         rchk(REG_EVENT, 32'h0, 32'h40);
      end
   endtask : t_filter
   task automatic t_crc;
      wr(REG_CTRL, 32'h2a);
      wr(REG_EVENT, 32'hff);
      avQ.delete();
      link.send(2'h1, 6'h05, 4'h0, cip0(2'h0, 8'h01), CIP1, 32'h55667788, 1'b1);
      settle;
      chk(32'(avQ.size()), 32'h0);
      rchk(REG_EVENT, 32'h50, 32'h58);
   endtask : t_crc
   task automatic t_seq;
      wr(REG_EVENT_EN, 32'h08);
      wr(REG_EVENT, 32'hff);
      link.send(2'h1, 6'h05, 4'h0, cip0(2'h0, 8'h05), CIP1, 32'h01020304, 1'b0);
      settle;
      rchk(REG_EVENT, 32'h48, 32'h48);
      chk({31'h0, irq}, 32'h1);
      wr(REG_EVENT, 32'h08);
      rchk(REG_EVENT, 32'h40, 32'h48);
      chk({31'h0, irq}, 32'h0);
   endtask : t_seq
   task automatic t_format;
      wr(REG_EVENT, 32'hff);
      avQ.delete();
      link.send(2'h1, 6'h05, 4'h0, cip0(2'h1, 8'h06), CIP1, 32'h0a0b0c0d, 1'b0);
      settle;
      rchk(REG_EVENT, 32'h20, 32'h20);
      chk(32'(avQ.size()), 32'h0);
   endtask : t_format
   task automatic t_stamp;
      logic [15:0] due;
      wr(REG_CTRL, 32'h0e);
      wr(REG_EVENT, 32'hff);
      fsyncCnt = 0;
      due = cycleTime + 16'h0080;
      link.send(2'h1, 6'h05, 4'h0, cip0(2'h0, 8'h06), {16'ha000, due}, 32'h0, 1'b0);
      repeat (150) @(posedge ref_clk);
      chk(32'(fsyncCnt), 32'h1);
      rchk(REG_EVENT, 32'h44, 32'h4c);
   endtask : t_stamp
   task automatic t_swrst;
      wr(REG_CTRL, 32'h2b);
      chk({30'h0, linkBusy, avBusy}, 32'h0);
      rchk(REG_CTRL, 32'h2b, 32'h3f);
      rchk(REG_FILTER, 32'h105, 32'h33f);
      wr(REG_CTRL, 32'h2a);
   endtask : t_swrst
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs;
      t_good;
      t_filter;
      t_crc;
      t_seq;
      t_format;
      t_stamp;
      t_swrst;
      stop_test;
   end
   initial begin
      repeat (30000) @(posedge ref_clk);
      mismatches++;
      stop_test;
   end
endmodule : test_iso_stream_receiver_control
`default_nettype wire
